// ---- video_monitor_pkg.sv ----
package video_monitor_pkg;

  // host register offsets
  localparam logic [7:0] ADDR_STATUS_DS1 = 8'h02;
  localparam logic [7:0] ADDR_STATUS_DS2 = 8'h03;
  localparam logic [7:0] ADDR_MASK_DS1   = 8'h37;
  localparam logic [7:0] ADDR_MASK_DS2   = 8'h38;

  localparam int REG_W    = 16;
  localparam int STATUS_W = 10;

  // status and mask bit positions, identical in both register pairs
  localparam int BIT_START_TRS  = 0;
  localparam int BIT_END_TRS    = 1;
  localparam int BIT_LUMA_CRC   = 2;
  localparam int BIT_CHROMA_CRC = 3;
  localparam int BIT_LINE_NUM   = 4;
  localparam int BIT_LUMA_CS    = 5;
  localparam int BIT_CHROMA_CS  = 6;
  localparam int BIT_AP_CRC     = 7;
  localparam int BIT_FF_CRC     = 8;
  localparam int BIT_VID_STD    = 9;

  // implemented bits per register
  localparam logic [15:0] STATUS_DS1_BITS = 16'h03FF;
  localparam logic [15:0] STATUS_DS2_BITS = 16'h027F;
  localparam logic [15:0] MASK_DS1_BITS   = 16'h03FF;
  localparam logic [15:0] MASK_DS2_BITS   = 16'h007F;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'h0000;

  // payload format codes
  localparam logic [3:0] FORMAT_SDTI_MAX  = 4'h5;
  localparam logic [3:0] FORMAT_SDI       = 4'h6;
  localparam logic [3:0] FORMAT_TDM       = 4'h8;
  localparam logic [3:0] FORMAT_HD_SDTI   = 4'h9;
  localparam logic [3:0] FORMAT_UNDEFINED = 4'hF;

  // edh flag group layout: one 5-bit group per region (anc, ap, ff)
  localparam int EDH_REGIONS = 3;
  localparam int EDH_GROUP_W = 5;
  localparam int EDH_FLAGS_W = 15;
  localparam int FLAG_EDH    = 0;
  localparam int FLAG_EDA    = 1;
  localparam int FLAG_IDH    = 2;
  localparam int FLAG_IDA    = 3;
  localparam int FLAG_UES    = 4;
  localparam logic [14:0] EDH_UES_ONLY  = 15'h4210;
  localparam logic [14:0] EDH_FLAGS_RST = 15'h0000;

endpackage : video_monitor_pkg

// ---- format_classifier.sv ----
`timescale 1ns/100ps
module format_classifier
  import video_monitor_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic       window_end,
  input  wire logic       hd_rate,
  input  wire logic       trs_seen,
  input  wire logic       sdti_header,
  input  wire logic [3:0] sdti_code,
  input  wire logic       tdm_header,
  output logic      [3:0] format_code
);

  logic       seen_trs;
  logic       seen_sdti;
  logic       seen_tdm;
  logic [3:0] held_sdti;
  logic       any_trs;
  logic       any_sdti;
  logic       any_tdm;
  logic [3:0] last_sdti;
  logic [3:0] next_code;

  assign any_trs   = seen_trs | trs_seen;
  assign any_sdti  = seen_sdti | sdti_header;
  assign any_tdm   = seen_tdm | tdm_header;
  assign last_sdti = sdti_header ? sdti_code : held_sdti;

  // evidence gathered over one field; a header on the closing cycle still counts
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      seen_trs  <= 1'b0;
      seen_sdti <= 1'b0;
      seen_tdm  <= 1'b0;
      held_sdti <= 4'h0;
    end else begin
      seen_trs  <= window_end ? 1'b0 : any_trs;
      seen_sdti <= window_end ? 1'b0 : any_sdti;
      seen_tdm  <= window_end ? 1'b0 : any_tdm;
      held_sdti <= last_sdti;
    end
  end

  always_comb begin
    next_code = FORMAT_UNDEFINED;
    if (any_trs) begin
      if (any_tdm) begin
        next_code = FORMAT_TDM;
      end else if (any_sdti) begin
        if (hd_rate) begin
          next_code = FORMAT_HD_SDTI;
        end else if (last_sdti > FORMAT_SDTI_MAX) begin
          next_code = FORMAT_SDTI_MAX;
        end else begin
          next_code = last_sdti;
        end
      end else begin
        next_code = FORMAT_SDI;
      end
    end
  end

  // loaded at each field start while running, forced to Fh when idle; reserved codes never produced
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      format_code <= FORMAT_UNDEFINED;
    end else if (window_end) begin
      format_code <= next_code;
    end
  end

  property p_idle_undefined;
    @(posedge sys_clk) disable iff (reset) !run |=> format_code == FORMAT_UNDEFINED;
  endproperty
  a_idle_undefined: assert property (p_idle_undefined)
    else $error("format code not undefined while idle");

endmodule : format_classifier

// ---- edh_flag_tracker.sv ----
`timescale 1ns/100ps
module edh_flag_tracker
  import video_monitor_pkg::*;
#(
  parameter int REGIONS = EDH_REGIONS
)(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   vblank,
  input  wire logic                   packet_seen,
  input  wire logic [EDH_FLAGS_W-1:0] rx_flags,
  input  wire logic                   rx_ap_crc_valid,
  input  wire logic                   rx_ff_crc_valid,
  input  wire logic [REGIONS-1:0]     local_crc_fault,
  input  wire logic                   recompute_enable,
  output logic                        presence,
  output logic      [EDH_FLAGS_W-1:0] received_flags,
  output logic      [EDH_FLAGS_W-1:0] updated_flags,
  output logic                        ap_crc_valid,
  output logic                        ff_crc_valid
);

  if (REGIONS * EDH_GROUP_W != EDH_FLAGS_W) begin : g_bad_regions
    $error("edh_flag_tracker: region count does not match flag layout");
  end

  logic                   vblank_d;
  logic                   blank_hit;
  logic                   blank_end;
  logic [EDH_FLAGS_W-1:0] recomputed;

  assign blank_end = vblank_d & ~vblank;

  for (genvar r = 0; r < REGIONS; r++) begin : g_region
    localparam int B = r * EDH_GROUP_W;
    // error seen here, error already flagged upstream, internal flags stay clear
    assign recomputed[B+FLAG_EDH] = local_crc_fault[r];
    assign recomputed[B+FLAG_EDA] = rx_flags[B+FLAG_EDH] | rx_flags[B+FLAG_EDA];
    assign recomputed[B+FLAG_IDH] = 1'b0;
    assign recomputed[B+FLAG_IDA] = 1'b0;
    assign recomputed[B+FLAG_UES] = rx_flags[B+FLAG_UES];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vblank_d  <= 1'b0;
      blank_hit <= 1'b0;
    end else begin
      vblank_d  <= vblank;
      // only packets inside blanking keep the flags alive
      blank_hit <= blank_end ? 1'b0 : (blank_hit | (packet_seen & vblank));
    end
  end

  // one flag set for both fields: each packet simply overwrites
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      presence       <= 1'b0;
      received_flags <= EDH_FLAGS_RST;
      updated_flags  <= EDH_FLAGS_RST;
      ap_crc_valid   <= 1'b0;
      ff_crc_valid   <= 1'b0;
    end else if (packet_seen) begin
      presence       <= 1'b1;
      received_flags <= rx_flags;
      updated_flags  <= recompute_enable ? recomputed : rx_flags;
      ap_crc_valid   <= rx_ap_crc_valid;
      ff_crc_valid   <= rx_ff_crc_valid;
    end else if (blank_end && !blank_hit) begin
      presence       <= 1'b0;
      received_flags <= EDH_FLAGS_RST;
      updated_flags  <= EDH_UES_ONLY;
      ap_crc_valid   <= 1'b0;
      ff_crc_valid   <= 1'b0;
    end
  end

  property p_presence_drop;
    @(posedge sys_clk) disable iff (reset)
      blank_end && !blank_hit && !packet_seen |=> !presence && updated_flags == EDH_UES_ONLY;
  endproperty
  a_presence_drop: assert property (p_presence_drop)
    else $error("edh presence kept after empty blanking");

  property p_valid_needs_presence;
    @(posedge sys_clk) disable iff (reset) !presence |-> !ap_crc_valid && !ff_crc_valid;
  endproperty
  a_valid_needs_presence: assert property (p_valid_needs_presence)
    else $error("crc valid set without edh presence");

endmodule : edh_flag_tracker

// ---- video_error_monitor.sv ----
// Function
// - classify payload format only while locked
// - format codes reset and idle at Fh
// - codes: SDTI 0-5, SDI 6, TDM 8, HD-SDTI 9
// - no trs: unknown; trs alone SDI, trs plus header SDTI/TDM
// - separate luma/chroma codes; chroma Fh in SD
// - presence flag drops after blanking without packet
// - store received edh flags per packet
// - recompute outgoing flags when enabled
// - single flag set, second field overwrites
// - no packets: outgoing unsupported flags set
// - crc validity bits cleared without presence
// - flags held until overwritten or empty blanking
// - error detection only in full processing mode
// - each error type owns one status bit
// - masks reset zero, set bit suppresses error
// - error pin low on any unmasked status
// - status clears per field or on read
// - status clears on unlock, bypass, standard change
// - status 02h/03h, masks 037h/038h layout
// - second stream set valid only in level B
// - trs fault on shift outside switching lines or bad protection bits
`timescale 1ns/100ps
module video_error_monitor
  import video_monitor_pkg::*;
#(
  parameter int CHANNELS = 2
)(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   locked,
  input  wire logic                   full_processing_select_n,
  input  wire logic                   sd_mode,
  input  wire logic                   level_b_detected,
  input  wire logic                   field_start,
  input  wire logic                   vblank,
  input  wire logic                   standard_change,
  input  wire logic                   switching_line,
  input  wire logic [CHANNELS-1:0]    trs_seen,
  input  wire logic [CHANNELS-1:0]    sdti_header,
  input  wire logic [CHANNELS*4-1:0]  sdti_code,
  input  wire logic [CHANNELS-1:0]    tdm_header,
  input  wire logic [1:0]             trs_shift_ds1,
  input  wire logic [1:0]             trs_code_bad_ds1,
  input  wire logic [1:0]             trs_shift_ds2,
  input  wire logic [1:0]             trs_code_bad_ds2,
  input  wire logic [7:0]             other_faults_ds1,
  input  wire logic [7:0]             other_faults_ds2,
  input  wire logic                   edh_packet_seen,
  input  wire logic [EDH_FLAGS_W-1:0] edh_rx_flags,
  input  wire logic                   edh_rx_ap_crc_valid,
  input  wire logic                   edh_rx_ff_crc_valid,
  input  wire logic [EDH_REGIONS-1:0] edh_local_crc_fault,
  input  wire logic                   edh_flag_recompute_enable,
  input  wire logic [7:0]             host_addr,
  input  wire logic                   host_rd,
  input  wire logic                   host_wr,
  input  wire logic [REG_W-1:0]       host_wdata,
  output logic      [REG_W-1:0]       host_rdata,
  output logic                        host_rdata_valid,
  output logic                        data_error_n,
  output logic      [7:0]             payload_format_codes,
  output logic                        edh_presence_flag,
  output logic      [EDH_FLAGS_W-1:0] edh_received_flags,
  output logic      [EDH_FLAGS_W-1:0] edh_updated_flags,
  output logic                        active_picture_crc_valid,
  output logic                        full_field_crc_valid
);

  if (CHANNELS != 2) begin : g_bad_channels
    $error("video_error_monitor: exactly luma and chroma channels supported");
  end

  logic                active;
  logic                active_ds2;
  logic [CHANNELS-1:0] chan_run;
  logic [3:0]          chan_code [CHANNELS];
  logic [REG_W-1:0]    video_error_status_stream1;
  logic [REG_W-1:0]    video_error_status_stream2;
  logic [REG_W-1:0]    video_error_mask_stream1;
  logic [REG_W-1:0]    video_error_mask_stream2;
  logic [REG_W-1:0]    evt_ds1;
  logic [REG_W-1:0]    evt_ds2;
  logic [REG_W-1:0]    next_status_ds1;
  logic [REG_W-1:0]    next_status_ds2;
  logic                clr_ds1;
  logic                clr_ds2;
  logic                rd_status_ds1;
  logic                rd_status_ds2;
  logic                edh_crc_ok;
  logic                next_error_n;
  logic [REG_W-1:0]    next_mask_ds1;
  logic [REG_W-1:0]    next_mask_ds2;

  // bypass pin low means pass-through: no errors or formats are monitored then, edh tracking still runs
  assign active     = locked & full_processing_select_n;
  assign active_ds2 = active & level_b_detected;

  // ---------------- payload format classification ----------------
  assign chan_run[0] = active;
  assign chan_run[1] = active & ~sd_mode;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_format
    format_classifier u_classifier (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .run         (chan_run[c]),
      .window_end  (field_start),
      .hd_rate     (~sd_mode),
      .trs_seen    (trs_seen[c]),
      .sdti_header (sdti_header[c]),
      .sdti_code   (sdti_code[c*4 +: 4]),
      .tdm_header  (tdm_header[c]),
      .format_code (chan_code[c])
    );
  end

  // classifiers already register their codes; this stage keeps the pins on flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      payload_format_codes <= {FORMAT_UNDEFINED, FORMAT_UNDEFINED};
    end else begin
      payload_format_codes <= {chan_code[1], chan_code[0]};
    end
  end

  // ---------------- edh packet tracking ----------------
  edh_flag_tracker #(
    .REGIONS (EDH_REGIONS)
  ) u_edh (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .vblank           (vblank),
    .packet_seen      (edh_packet_seen),
    .rx_flags         (edh_rx_flags),
    .rx_ap_crc_valid  (edh_rx_ap_crc_valid),
    .rx_ff_crc_valid  (edh_rx_ff_crc_valid),
    .local_crc_fault  (edh_local_crc_fault),
    .recompute_enable (edh_flag_recompute_enable),
    .presence         (edh_presence_flag),
    .received_flags   (edh_received_flags),
    .updated_flags    (edh_updated_flags),
    .ap_crc_valid     (active_picture_crc_valid),
    .ff_crc_valid     (full_field_crc_valid)
  );

  // ---------------- error event collection ----------------
  // edh crc faults only mean something for SD with packets actually present
  assign edh_crc_ok = sd_mode & edh_presence_flag;

  always_comb begin
    evt_ds1 = '0;
    evt_ds2 = '0;
    evt_ds1[BIT_START_TRS] = (trs_shift_ds1[0] & ~switching_line) | trs_code_bad_ds1[0];
    evt_ds1[BIT_END_TRS]   = (trs_shift_ds1[1] & ~switching_line) | trs_code_bad_ds1[1];
    evt_ds2[BIT_START_TRS] = (trs_shift_ds2[0] & ~switching_line) | trs_code_bad_ds2[0];
    evt_ds2[BIT_END_TRS]   = (trs_shift_ds2[1] & ~switching_line) | trs_code_bad_ds2[1];
    evt_ds1[BIT_VID_STD:BIT_LUMA_CRC] = other_faults_ds1;
    evt_ds2[BIT_VID_STD:BIT_LUMA_CRC] = other_faults_ds2;
    evt_ds1[BIT_AP_CRC] = other_faults_ds1[BIT_AP_CRC-BIT_LUMA_CRC] & edh_crc_ok;
    evt_ds1[BIT_FF_CRC] = other_faults_ds1[BIT_FF_CRC-BIT_LUMA_CRC] & edh_crc_ok;
    evt_ds1 = evt_ds1 & STATUS_DS1_BITS & {REG_W{active}};
    evt_ds2 = evt_ds2 & STATUS_DS2_BITS & {REG_W{active_ds2}};
  end

  assign rd_status_ds1 = host_rd && (host_addr == ADDR_STATUS_DS1);
  assign rd_status_ds2 = host_rd && (host_addr == ADDR_STATUS_DS2);

  // the clear and a fresh event in one cycle: the event survives
  assign clr_ds1 = field_start | rd_status_ds1 | standard_change | ~active;
  assign clr_ds2 = field_start | rd_status_ds2 | standard_change | ~active_ds2;

  assign next_status_ds1 = (clr_ds1 ? STATUS_RESET : video_error_status_stream1) | evt_ds1;
  assign next_status_ds2 = (clr_ds2 ? STATUS_RESET : video_error_status_stream2) | evt_ds2;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      video_error_status_stream1 <= STATUS_RESET;
      video_error_status_stream2 <= STATUS_RESET;
    end else begin
      video_error_status_stream1 <= next_status_ds1;
      video_error_status_stream2 <= next_status_ds2;
    end
  end

  // ---------------- mask registers ----------------
  // next values also feed the pin, so a mask write and the pin move on one edge
  assign next_mask_ds1 = (host_wr && host_addr == ADDR_MASK_DS1) ?
                         (host_wdata & MASK_DS1_BITS) : video_error_mask_stream1;
  assign next_mask_ds2 = (host_wr && host_addr == ADDR_MASK_DS2) ?
                         (host_wdata & MASK_DS2_BITS) : video_error_mask_stream2;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      video_error_mask_stream1 <= MASK_RESET;
      video_error_mask_stream2 <= MASK_RESET;
    end else begin
      video_error_mask_stream1 <= next_mask_ds1;
      video_error_mask_stream2 <= next_mask_ds2;
    end
  end

  // ---------------- host read port ----------------
  // read data is the value before the same edge applies clear-on-read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      host_rdata       <= '0;
      host_rdata_valid <= 1'b0;
    end else begin
      host_rdata_valid <= host_rd;
      if (host_rd) begin
        case (host_addr)
          ADDR_STATUS_DS1: host_rdata <= video_error_status_stream1;
          ADDR_STATUS_DS2: host_rdata <= video_error_status_stream2;
          ADDR_MASK_DS1:   host_rdata <= video_error_mask_stream1;
          ADDR_MASK_DS2:   host_rdata <= video_error_mask_stream2;
          default:         host_rdata <= '0;
        endcase
      end
    end
  end

  // ---------------- error pin ----------------
  // built from next status so the pin moves on the same edge as the register
  assign next_error_n = ~|((next_status_ds1 & ~next_mask_ds1) |
                           (next_status_ds2 & ~next_mask_ds2));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_error_n <= 1'b1;
    end else begin
      data_error_n <= next_error_n;
    end
  end

  // ---------------- assertions ----------------
  property p_error_nor;
    @(posedge sys_clk) disable iff (reset)
      data_error_n == !(|((video_error_status_stream1 & ~video_error_mask_stream1) |
                          (video_error_status_stream2 & ~video_error_mask_stream2)));
  endproperty
  a_error_nor: assert property (p_error_nor)
    else $error("error pin does not match unmasked status");

  property p_read_clears;
    @(posedge sys_clk) disable iff (reset)
      rd_status_ds1 && evt_ds1 == '0 |=> video_error_status_stream1 == '0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");

  property p_read_precleared;
    @(posedge sys_clk) disable iff (reset)
      rd_status_ds1 |=> host_rdata_valid && host_rdata == $past(video_error_status_stream1);
  endproperty
  a_read_precleared: assert property (p_read_precleared)
    else $error("read did not return pre-clear status");

  property p_unlock_clears;
    @(posedge sys_clk) disable iff (reset)
      !locked |=> video_error_status_stream1 == '0 && video_error_status_stream2 == '0;
  endproperty
  a_unlock_clears: assert property (p_unlock_clears)
    else $error("status held while unlocked");

  property p_mask_reset;
    @(posedge sys_clk) reset |=> video_error_mask_stream1 == '0 && video_error_mask_stream2 == '0;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not zero after reset");

  property p_event_sets;
    @(posedge sys_clk) disable iff (reset)
      evt_ds1[BIT_START_TRS] ##1 !rd_status_ds1 && !field_start && active
        |-> video_error_status_stream1[BIT_START_TRS];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("trs event did not set its status bit");

  property p_ds2_needs_level_b;
    @(posedge sys_clk) disable iff (reset)
      !level_b_detected |=> video_error_status_stream2 == '0;
  endproperty
  a_ds2_needs_level_b: assert property (p_ds2_needs_level_b)
    else $error("second stream status outside level B");

  property p_bypass_quiet;
    @(posedge sys_clk) disable iff (reset)
      !full_processing_select_n [*2] |-> data_error_n;
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet)
    else $error("error pin active in bypass");

  property p_mask_suppresses;
    @(posedge sys_clk) disable iff (reset)
      video_error_mask_stream1 == MASK_DS1_BITS && video_error_mask_stream2 == MASK_DS2_BITS
        && !level_b_detected && !host_wr |=> data_error_n;
  endproperty
  a_mask_suppresses: assert property (p_mask_suppresses)
    else $error("fully masked errors still reported");

endmodule : video_error_monitor

// ---- host_model.sv ----
`timescale 1ns/100ps
module host_model
  import video_monitor_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic [REG_W-1:0] host_rdata,
  input  wire logic             host_rdata_valid,
  output logic      [7:0]       host_addr = 8'h00,
  output logic                  host_rd = 1'h0,
  output logic                  host_wr = 1'h0,
  output logic      [REG_W-1:0] host_wdata = 16'h0000
);
  // callers read outside vblank so edh flags never move under a read
  // status may be cleared by a field start before it is read
  task automatic rd(input logic [7:0] a, output logic [REG_W-1:0] d);
    int n;
    d = 16'hXXXX;
    @(posedge sys_clk);
    host_addr <= a;
    host_rd <= 1'h1;
    @(posedge sys_clk);
    host_rd <= 1'h0;
    for (n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      if (host_rdata_valid === 1'h1) begin
        d = host_rdata;
        break;
      end
    end
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [REG_W-1:0] v);
    @(posedge sys_clk);
    host_addr <= a;
    host_wdata <= v;
    host_wr <= 1'h1;
    @(posedge sys_clk);
    host_wr <= 1'h0;
  endtask : wr
endmodule : host_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  import video_monitor_pkg::*;
  logic sys_clk = 0, reset = 1, locked = 0, full_processing_select_n = 1;
  logic sd_mode = 0, level_b_detected = 0, field_start = 0, vblank = 0;
  logic standard_change = 0, switching_line = 0, edh_packet_seen = 0;
  logic edh_rx_ap_crc_valid = 0, edh_rx_ff_crc_valid = 0, edh_flag_recompute_enable = 0;
  logic [1:0] trs_seen = 0, sdti_header = 0, tdm_header = 0, trs_shift_ds1 = 0;
  logic [1:0] trs_code_bad_ds1 = 0, trs_shift_ds2 = 0, trs_code_bad_ds2 = 0;
  logic [7:0] sdti_code = 0, other_faults_ds1 = 0, other_faults_ds2 = 0;
  logic [7:0] host_addr, payload_format_codes;
  logic [14:0] edh_rx_flags = 0, edh_received_flags, edh_updated_flags;
  logic [2:0] edh_local_crc_fault = 0;
  logic host_rd, host_wr, host_rdata_valid, data_error_n, edh_presence_flag;
  logic active_picture_crc_valid, full_field_crc_valid;
  logic [15:0] host_wdata, host_rdata, d;
  int failures = 0, cmp_count = 0, cycles = 0;
  video_error_monitor uut (.*);
  host_model host (.*);
  always #5 sys_clk = ~sys_clk;
  // whole run needs well under 1500 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("counts: failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic ev(input logic [7:0] f1, input logic [7:0] f2, input logic [1:0] bad,
                    input logic [1:0] sh);
    @(posedge sys_clk);
    other_faults_ds1 <= f1;
    other_faults_ds2 <= f2;
    trs_code_bad_ds1 <= bad;
    trs_shift_ds1 <= sh;
    @(posedge sys_clk);
    {other_faults_ds1, other_faults_ds2, trs_code_bad_ds1, trs_shift_ds1} <= '0;
    #1;
  endtask : ev
  task automatic fld();
    @(posedge sys_clk) field_start <= 1'h1;
    @(posedge sys_clk) field_start <= 1'h0;
    #1;
  endtask : fld
  task automatic pkt(input logic [14:0] f);
    @(posedge sys_clk);
    edh_rx_flags <= f;
    edh_rx_ap_crc_valid <= 1'h1;
    edh_rx_ff_crc_valid <= 1'h1;
    edh_packet_seen <= 1'h1;
    @(posedge sys_clk) edh_packet_seen <= 1'h0;
    #1;
  endtask : pkt
  task automatic vb();
    @(posedge sys_clk) vblank <= 1'h1;
    @(posedge sys_clk) vblank <= 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : vb
  task automatic t_reset();
    host.rd(ADDR_MASK_DS1, d);
    chk(d, MASK_RESET, "mask reset");
    chk(payload_format_codes, 16'h00FF, "codes reset");
    chk(data_error_n, 16'h0001, "pin idle");
    $display("test reset done");
  endtask : t_reset
  task automatic t_errors();
    ev(8'h00, 8'h00, 2'h1, 2'h0);
    chk(data_error_n, 16'h0000, "pin low");
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0001, "pre-clear read");
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0000, "cleared by read");
    chk(data_error_n, 16'h0001, "pin released");
    host.wr(ADDR_MASK_DS1, 16'hFFFF);
    host.rd(ADDR_MASK_DS1, d);
    chk(d, MASK_DS1_BITS, "mask1 bits");
    host.wr(ADDR_MASK_DS2, 16'hFFFF);
    host.rd(ADDR_MASK_DS2, d);
    chk(d, MASK_DS2_BITS, "mask2 bits");
    host.rd(8'h10, d);
    chk(d, 16'h0000, "unmapped");
    ev(8'h01, 8'h00, 2'h0, 2'h0);
    chk(data_error_n, 16'h0001, "masked pin");
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0004, "luma crc bit");
    host.wr(ADDR_MASK_DS1, 16'h0000);
    host.wr(ADDR_MASK_DS2, 16'h0000);
    $display("test errors done");
  endtask : t_errors
  task automatic t_clears();
    ev(8'h01, 8'h00, 2'h0, 2'h0);
    fld();
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0000, "field clear");
    ev(8'h01, 8'h00, 2'h0, 2'h0);
    @(posedge sys_clk) standard_change <= 1'h1;
    @(posedge sys_clk) standard_change <= 1'h0;
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0000, "std change clear");
    ev(8'h01, 8'h00, 2'h0, 2'h0);
    @(posedge sys_clk) locked <= 1'h0;
    @(posedge sys_clk) locked <= 1'h1;
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0000, "unlock clear");
    @(posedge sys_clk) full_processing_select_n <= 1'h0;
    ev(8'h01, 8'h00, 2'h1, 2'h0);
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0000, "bypass inactive");
    full_processing_select_n <= 1'h1;
    ev(8'h00, 8'h01, 2'h0, 2'h0);
    host.rd(ADDR_STATUS_DS2, d);
    chk(d, 16'h0000, "ds2 without level b");
    level_b_detected <= 1'h1;
    ev(8'h00, 8'h01, 2'h0, 2'h0);
    host.rd(ADDR_STATUS_DS2, d);
    chk(d, 16'h0004, "ds2 level b");
    switching_line <= 1'h1;
    ev(8'h00, 8'h00, 2'h0, 2'h1);
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0000, "shift on switching");
    switching_line <= 1'h0;
    ev(8'h00, 8'h00, 2'h0, 2'h2);
    host.rd(ADDR_STATUS_DS1, d);
    chk(d, 16'h0002, "end trs shift");
    $display("test clears done");
  endtask : t_clears
  task automatic t_format();
    int k;
    logic [3:0] ex [4];
    ex = '{FORMAT_UNDEFINED, FORMAT_SDI, FORMAT_TDM, FORMAT_HD_SDTI};
    fld();
    for (k = 0; k < 5; k++) begin
      @(posedge sys_clk);
      sd_mode <= (k == 4);
      trs_seen <= (k > 0) ? 2'h3 : 2'h0;
      tdm_header <= {1'h0, k == 2};
      sdti_header <= {1'h0, k == 3 || k == 4};
      sdti_code <= 8'h03;
      @(posedge sys_clk) {trs_seen, tdm_header, sdti_header} <= '0;
      fld();
      repeat (2) @(posedge sys_clk);
      #1;
      if (k < 4) chk(payload_format_codes, {(k > 0) ? 4'h6 : 4'hF, ex[k]}, "format");
      else chk(payload_format_codes, {4'hF, 4'h3}, "sd sdti, chroma");
    end
    @(posedge sys_clk) locked <= 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(payload_format_codes, 16'h00FF, "unlocked");
    @(posedge sys_clk);
    locked <= 1'h1;
    sd_mode <= 1'h0;
    $display("test format done");
  endtask : t_format
  task automatic t_edh();
    // packets arrive inside blanking
    @(posedge sys_clk) vblank <= 1'h1;
    pkt(15'h1234);
    chk(edh_presence_flag, 16'h0001, "presence");
    chk(edh_received_flags, 16'h1234, "rx flags");
    chk(edh_updated_flags, 16'h1234, "pass flags");
    chk(active_picture_crc_valid, 16'h0001, "ap valid");
    chk(full_field_crc_valid, 16'h0001, "ff valid");
    @(posedge sys_clk);
    edh_flag_recompute_enable <= 1'h1;
    edh_local_crc_fault <= 3'h5;
    pkt(15'h7FFF);
    chk(edh_received_flags, 16'h7FFF, "overwrite");
    chk(edh_updated_flags, 16'h4E53, "recompute");
    vb();
    chk(edh_received_flags, 16'h7FFF, "held");
    vb();
    chk(edh_presence_flag, 16'h0000, "presence drop");
    chk(edh_received_flags, 16'h0000, "rx cleared");
    chk(edh_updated_flags, {1'h0, EDH_UES_ONLY}, "ues");
    chk(active_picture_crc_valid, 16'h0000, "ap valid clr");
    chk(full_field_crc_valid, 16'h0000, "ff valid clr");
    $display("test edh done");
  endtask : t_edh
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'h0;
    locked <= 1'h1;
    t_reset();
    t_errors();
    t_clears();
    t_format();
    t_edh();
    complete_run();
  end
endmodule : tb
